// ---- pkg/vsr_pkg.sv ----
// Notes on behaviour
// - Power register holds upper byte of voltage times current.
// - Reading secondary status snapshots it.
// - Current limit strap sampled at each enable rise, read-only.
// - Alert level resets 100 C, drives alert.
// - Fast ramp rate register, default ten.
// - Slow ramp rate fifth of fast, default two.
// - Ramp to boot voltage until first 01h, 02h or 03h command.
// - Ceiling register rejects higher codes, default FBh.
// - Voltage setting register, read/write, resets zero.
// - Power state register, read/write, resets zero.
// - Signed margin steps added to setting.
// - Command 01h ramps at fast rate.
// - Command 02h ramps at slow rate.
// - Command 03h lets output decay down.
// - One boot strap for both rails; ground 1.1 V.
// - Strap resistor decode to boot voltage table.
// - Rail addresses 0000 core, 0001 aux.
// - Temperature in degrees, zero when unsupported.
// - Current limit at 1 A per bit.
package vsr_pkg;
  localparam int NRAIL = 2;
  localparam logic [3:0] ADDR_CORE = 4'h0;
  localparam logic [3:0] ADDR_AUX  = 4'h1;
  localparam logic [3:0] CMD_FAST  = 4'h1;
  localparam logic [3:0] CMD_SLOW  = 4'h2;
  localparam logic [3:0] CMD_DECAY = 4'h3;
  localparam logic [3:0] CMD_GET   = 4'h4;
  localparam logic [3:0] CMD_SET   = 4'h5;
  localparam logic [1:0] ACK_OK     = 2'h2;
  localparam logic [1:0] ACK_REJECT = 2'h1;
  // Register indices on the link
  localparam logic [7:0] IDX_IOUT   = 8'h15;
  localparam logic [7:0] IDX_VOUT   = 8'h16;
  localparam logic [7:0] IDX_TEMP   = 8'h17;
  localparam logic [7:0] IDX_POWER  = 8'h18;
  localparam logic [7:0] IDX_STAT2  = 8'h11;
  localparam logic [7:0] IDX_SNAP   = 8'h1C;
  localparam logic [7:0] IDX_ICC    = 8'h21;
  localparam logic [7:0] IDX_ALERT  = 8'h22;
  localparam logic [7:0] IDX_FAST   = 8'h24;
  localparam logic [7:0] IDX_SLOW   = 8'h25;
  localparam logic [7:0] IDX_BOOT   = 8'h26;
  localparam logic [7:0] IDX_CEIL   = 8'h30;
  localparam logic [7:0] IDX_SETV   = 8'h31;
  localparam logic [7:0] IDX_PSTATE = 8'h32;
  localparam logic [7:0] IDX_MARGIN = 8'h33;
  localparam logic [7:0] IDX_MULTI  = 8'h34;
  // Reset values
  localparam logic [7:0] RST_POWER = 8'h01;
  localparam logic [7:0] RST_ALERT = 8'h64;
  localparam logic [7:0] RST_FAST  = 8'h0A;
  localparam logic [7:0] RST_SLOW  = 8'h02;
  localparam logic [7:0] RST_CEIL  = 8'hFB;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  // Boot codes by strap: grounded, 10k, 20k, 30k, 40k, 50k, 60k, supply
  localparam logic [7:0] BOOT_CODE_TBL [8] = '{8'hAB, 8'h00, 8'h83, 8'h97,
                                               8'hAB, 8'hBF, 8'hDD, 8'hDD};
  // Timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int US_NS         = 1000;
  localparam int US_CYC        = US_NS / CLK_PERIOD_NS;
  localparam int STEP_MV       = 5;
  localparam int SCLK_HALF_CYC = 16;
  // Frame layout: 24 bits out, 10 bits back
  localparam int TX_BITS    = 24;
  localparam int FRAME_BITS = 34;
  // Host register map on the system bus
  localparam logic [3:0] HOFF_CTRL   = 4'h0;
  localparam logic [3:0] HOFF_STATUS = 4'h4;
  localparam logic [1:0] SYNC_RST    = 2'b00;
endpackage : vsr_pkg

// ---- pkg/vsr_link_if.sv ----
`timescale 1ns/1ps
interface vsr_link_if;
  logic sclk;
  logic cs_n;
  logic host_sdio_o;
  logic host_sdio_oe;
  logic dev_sdio_o;
  logic dev_sdio_oe;
  logic sdio;
  // Shared data wire with pull-up when nobody drives
  assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);
  modport host (output sclk, output cs_n, output host_sdio_o, output host_sdio_oe,
                input sdio);
  modport dev (input sclk, input cs_n, input sdio, output dev_sdio_o,
               output dev_sdio_oe);
endinterface : vsr_link_if

// ---- rtl/vsr_device.sv ----
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module vsr_device (
  input  wire logic                                   CORE_CLK,
  input  wire logic                                   RSTN,
  input  wire logic                                   EN,
  input  wire logic [7:0]                             VOUT_MEAS,
  input  wire logic [7:0]                             IOUT_MEAS,
  input  wire logic [7:0]                             TEMP_MEAS,
  input  wire logic [7:0]                             STATUS2_IN,
  input  wire logic [7:0]                             CURRENT_LIMIT_STRAP_PIN,
  input  wire logic [2:0]                             BOOT_STRAP_SEL,
  vsr_link_if.dev                                     LINK,
  output logic                                        THERMAL_ALERT_OUTPUT,
  output logic [vsr_pkg::NRAIL-1:0][7:0]              VOLTAGE_CODE
);
  import vsr_pkg::*;

  // Three-stage sync: sclk, cs_n, sdio, enable
  logic [3:0] raw;
  logic [3:0] s1_q;
  logic [3:0] s2_q;
  logic [3:0] s3_q;
  logic [3:0] st_q;
  logic [3:0] prev_q;
  assign raw = {EN, LINK.sdio, LINK.cs_n, LINK.sclk};

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s1_q   <= 4'b0110;
      s2_q   <= 4'b0110;
      s3_q   <= 4'b0110;
      prev_q <= 4'b0110;
    end else begin
      s1_q   <= raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      prev_q <= st_q;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
          st_q[gi] <= (gi == 1 || gi == 2);
        end else if (s2_q[gi] == s3_q[gi]) begin
          st_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  logic sclk_rise;
  logic sclk_fall;
  logic cs_idle;
  logic en_rise;
  assign sclk_rise = st_q[0] & ~prev_q[0];
  assign sclk_fall = ~st_q[0] & prev_q[0];
  assign cs_idle   = st_q[1];
  assign en_rise   = st_q[3] & ~prev_q[3];

  // Frame receive
  logic [5:0]  cnt_q;
  logic [23:0] rx_q;
  logic        exec_q;
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cnt_q  <= '0;
      rx_q   <= '0;
      exec_q <= 1'b0;
    end else begin
      exec_q <= 1'b0;
      if (cs_idle) begin
        cnt_q <= '0;
      end else if (sclk_rise) begin
        if (cnt_q < 6'(FRAME_BITS)) begin
          cnt_q <= cnt_q + 6'd1;
        end
        if (cnt_q < 6'(TX_BITS)) begin
          rx_q <= {rx_q[22:0], st_q[2]};
        end
        exec_q <= (cnt_q == 6'(TX_BITS - 1));
      end
    end
  end

  logic [3:0] f_addr;
  logic [3:0] f_cmd;
  logic [7:0] f_idx;
  logic [7:0] f_dat;
  logic       hit;
  logic       rail;
  assign f_addr = rx_q[23:20];
  assign f_cmd  = rx_q[19:16];
  assign f_idx  = rx_q[15:8];
  assign f_dat  = rx_q[7:0];
  assign hit    = (f_addr == ADDR_CORE) || (f_addr == ADDR_AUX);
  assign rail   = (f_addr == ADDR_AUX);

  // Registers
  logic [7:0] power_q;
  logic [7:0] snap_q;
  logic [7:0] icc_q;
  logic [7:0] alert_lvl_q;
  logic [7:0] fast_q;
  logic [7:0] slow_q;
  logic [7:0] boot_q;
  logic [7:0] ceil_q;
  logic [7:0] multi_q;
  logic [NRAIL-1:0][7:0] setv_q;
  logic [NRAIL-1:0][7:0] pstate_q;
  logic [NRAIL-1:0][7:0] margin_q;
  logic [NRAIL-1:0][3:0] mode_q;
  logic [NRAIL-1:0]      hold_boot_q;

  // Read mux
  logic [7:0] rdata;
  logic       rok;
  always_comb begin
    rok   = 1'b1;
    rdata = 8'h00;
    case (f_idx)
      IDX_IOUT:   rdata = IOUT_MEAS;
      IDX_VOUT:   rdata = VOUT_MEAS;
      IDX_TEMP:   rdata = TEMP_MEAS;
      IDX_POWER:  rdata = power_q;
      IDX_STAT2:  rdata = STATUS2_IN;
      IDX_SNAP:   rdata = snap_q;
      IDX_ICC:    rdata = icc_q;
      IDX_ALERT:  rdata = alert_lvl_q;
      IDX_FAST:   rdata = fast_q;
      IDX_SLOW:   rdata = slow_q;
      IDX_BOOT:   rdata = boot_q;
      IDX_CEIL:   rdata = ceil_q;
      IDX_SETV:   rdata = setv_q[rail];
      IDX_PSTATE: rdata = pstate_q[rail];
      IDX_MARGIN: rdata = margin_q[rail];
      IDX_MULTI:  rdata = multi_q;
      default:    rok = 1'b0;
    endcase
  end

  // Command decode
  logic is_setv;
  logic over;
  logic wr_ok;
  logic cmd_ok;
  assign is_setv = (f_cmd == CMD_FAST) || (f_cmd == CMD_SLOW) || (f_cmd == CMD_DECAY);
  assign over    = (f_cmd == CMD_SET && f_idx == IDX_SETV) ? (f_dat > ceil_q)
                                                           : (f_idx > ceil_q);
  assign wr_ok   = (f_idx == IDX_ALERT) || (f_idx == IDX_CEIL) || (f_idx == IDX_SETV) ||
                   (f_idx == IDX_PSTATE) || (f_idx == IDX_MARGIN) || (f_idx == IDX_MULTI);
  assign cmd_ok  = (is_setv && !over) || (f_cmd == CMD_GET && rok) ||
                   (f_cmd == CMD_SET && wr_ok && !(f_idx == IDX_SETV && over));
  logic do_exec;
  assign do_exec = exec_q && hit && cmd_ok;

  // Shared register updates
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      alert_lvl_q <= RST_ALERT;
      ceil_q      <= RST_CEIL;
      multi_q     <= RST_ZERO;
      fast_q      <= RST_FAST;
      slow_q      <= RST_SLOW;
    end else if (do_exec && f_cmd == CMD_SET) begin
      if (f_idx == IDX_ALERT) alert_lvl_q <= f_dat;
      if (f_idx == IDX_CEIL) ceil_q <= f_dat;
      if (f_idx == IDX_MULTI) multi_q <= f_dat;
    end
  end

  // Status snapshot on read
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      snap_q <= RST_ZERO;
    end else if (do_exec && f_cmd == CMD_GET && f_idx == IDX_STAT2) begin
      snap_q <= STATUS2_IN;
    end
  end

  // Straps caught at enable
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      icc_q  <= RST_ZERO;
      boot_q <= RST_ZERO;
    end else if (en_rise) begin
      icc_q  <= CURRENT_LIMIT_STRAP_PIN;
      boot_q <= BOOT_CODE_TBL[BOOT_STRAP_SEL];
    end
  end

  // Telemetry
  logic [15:0] prod;
  assign prod = VOUT_MEAS * IOUT_MEAS;
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      power_q              <= RST_POWER;
      THERMAL_ALERT_OUTPUT <= 1'b0;
    end else begin
      power_q              <= prod[15:8];
      THERMAL_ALERT_OUTPUT <= (TEMP_MEAS != 8'h00) && (TEMP_MEAS >= alert_lvl_q);
    end
  end

  // Microsecond tick for ramps
  logic [7:0] us_q;
  logic       tick;
  assign tick = (us_q == 8'(US_CYC - 1));
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      us_q <= '0;
    end else begin
      us_q <= tick ? 8'd0 : us_q + 8'd1;
    end
  end

  // Per-rail setting and ramp
  generate
    for (gi = 0; gi < NRAIL; gi++) begin : g_rail
      logic       mine;
      logic [9:0] sum;
      logic [7:0] target;
      logic [7:0] rate;
      logic [9:0] acc_q;
      logic       step;
      assign mine = do_exec && (rail == gi);
      assign sum  = {2'b00, setv_q[gi]} + {{2{margin_q[gi][7]}}, margin_q[gi]};
      assign target = hold_boot_q[gi] ? boot_q :
                      (sum[9] ? 8'h00 : (sum[8] ? 8'hFF : sum[7:0]));
      assign rate = (mode_q[gi] == CMD_SLOW) ? slow_q : fast_q;
      assign step = (acc_q >= 10'(STEP_MV)) && (target != VOLTAGE_CODE[gi]);

      always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
          setv_q[gi]      <= RST_ZERO;
          pstate_q[gi]    <= RST_ZERO;
          margin_q[gi]    <= RST_ZERO;
          mode_q[gi]      <= CMD_FAST;
          hold_boot_q[gi] <= 1'b1;
        end else if (!st_q[3]) begin
          hold_boot_q[gi] <= 1'b1;
        end else if (mine && is_setv) begin
          setv_q[gi]      <= f_idx;
          mode_q[gi]      <= f_cmd;
          hold_boot_q[gi] <= 1'b0;
        end else if (mine && f_cmd == CMD_SET) begin
          if (f_idx == IDX_SETV) setv_q[gi] <= f_dat;
          if (f_idx == IDX_PSTATE) pstate_q[gi] <= f_dat;
          if (f_idx == IDX_MARGIN) margin_q[gi] <= f_dat;
        end
      end

      always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
          VOLTAGE_CODE[gi] <= RST_ZERO;
          acc_q            <= '0;
        end else if (!st_q[3]) begin
          VOLTAGE_CODE[gi] <= RST_ZERO;
          acc_q            <= '0;
        end else if (mode_q[gi] == CMD_DECAY && target < VOLTAGE_CODE[gi]) begin
          VOLTAGE_CODE[gi] <= target;
          acc_q            <= '0;
        end else if (target == VOLTAGE_CODE[gi]) begin
          acc_q <= '0;
        end else begin
          acc_q <= acc_q + (tick ? {2'b00, rate} : 10'd0) - (step ? 10'(STEP_MV) : 10'd0);
          if (step) begin
            VOLTAGE_CODE[gi] <= (target > VOLTAGE_CODE[gi]) ? VOLTAGE_CODE[gi] + 8'd1
                                                             : VOLTAGE_CODE[gi] - 8'd1;
          end
        end
      end
    end
  endgenerate

  // Answer: two ack bits then eight data bits, driven after falling clock
  logic [9:0] tx_q;
  logic       drive_q;
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_q             <= '0;
      drive_q          <= 1'b0;
      LINK.dev_sdio_o  <= 1'b1;
      LINK.dev_sdio_oe <= 1'b0;
    end else if (cs_idle) begin
      drive_q          <= 1'b0;
      LINK.dev_sdio_oe <= 1'b0;
    end else if (exec_q) begin
      drive_q <= hit;
      tx_q    <= {cmd_ok ? ACK_OK : ACK_REJECT,
                  (cmd_ok && f_cmd == CMD_GET) ? rdata : 8'h00};
    end else if (sclk_fall && drive_q) begin
      if (cnt_q >= 6'(TX_BITS) && cnt_q < 6'(FRAME_BITS)) begin
        LINK.dev_sdio_oe <= 1'b1;
        LINK.dev_sdio_o  <= tx_q[9];
        tx_q             <= {tx_q[8:0], 1'b0};
      end else begin
        LINK.dev_sdio_oe <= 1'b0;
      end
    end
  end
endmodule : vsr_device

// ---- rtl/vsr_host.sv ----
`timescale 1ns/1ps
module vsr_host (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  vsr_link_if.host         LINK
);
  import vsr_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_END} vsr_hstate_t;
  vsr_hstate_t state_q;

  // Data line sync
  logic [2:0] sd_q;
  logic       sd_st_q;
  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sd_q    <= 3'b111;
      sd_st_q <= 1'b1;
    end else begin
      sd_q <= {sd_q[1:0], LINK.sdio};
      if (sd_q[1] == sd_q[2]) sd_st_q <= sd_q[2];
    end
  end

  // System bus slave, zero wait states
  logic       wr_pend_q;
  logic [3:0] waddr_q;
  logic       busy_q;
  logic [1:0] ack_q;
  logic [7:0] rdat_q;
  logic       start;
  assign start = wr_pend_q && waddr_q == HOFF_CTRL && !busy_q;

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_pend_q <= 1'b0;
      waddr_q   <= '0;
      HRDATA    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      wr_pend_q <= 1'b0;
      if (HSEL && HTRANS[1] && HREADY) begin
        wr_pend_q <= HWRITE;
        waddr_q   <= HADDR[3:0];
        HRDATA    <= (!HWRITE && HADDR[3:0] == HOFF_STATUS) ?
                     {16'h0000, rdat_q, 5'b00000, ack_q, busy_q} : 32'h0000_0000;
      end
    end
  end

  // Frame engine; link clock made by division
  logic [23:0] frame_q;
  logic [5:0]  bitn_q;
  logic [4:0]  div_q;
  logic [9:0]  rx_q;
  logic        half;
  assign half = (div_q == 5'(SCLK_HALF_CYC - 1));

  always_ff @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q           <= H_IDLE;
      frame_q           <= '0;
      bitn_q            <= '0;
      div_q             <= '0;
      rx_q              <= '0;
      busy_q            <= 1'b0;
      ack_q             <= '0;
      rdat_q            <= '0;
      LINK.sclk         <= 1'b0;
      LINK.cs_n         <= 1'b1;
      LINK.host_sdio_o  <= 1'b1;
      LINK.host_sdio_oe <= 1'b0;
    end else begin
      case (state_q)
        H_IDLE: begin
          if (start) begin
            frame_q           <= {HWDATA[22:0], 1'b0};
            LINK.host_sdio_o  <= HWDATA[23];
            LINK.host_sdio_oe <= 1'b1;
            LINK.cs_n         <= 1'b0;
            busy_q            <= 1'b1;
            bitn_q            <= '0;
            div_q             <= '0;
            state_q           <= H_SHIFT;
          end
        end
        H_SHIFT: begin
          div_q <= half ? 5'd0 : div_q + 5'd1;
          if (half && !LINK.sclk) begin
            LINK.sclk <= 1'b1;
            if (bitn_q >= 6'(TX_BITS)) rx_q <= {rx_q[8:0], sd_st_q};
          end else if (half) begin
            LINK.sclk <= 1'b0;
            bitn_q    <= bitn_q + 6'd1;
            if (bitn_q == 6'(FRAME_BITS - 1)) begin
              state_q <= H_END;
            end else if (bitn_q < 6'(TX_BITS - 1)) begin
              LINK.host_sdio_o <= frame_q[23];
              frame_q          <= {frame_q[22:0], 1'b0};
            end else begin
              LINK.host_sdio_oe <= 1'b0;
            end
          end
        end
        H_END: begin
          div_q <= div_q + 5'd1;
          if (half) begin
            LINK.cs_n <= 1'b1;
            busy_q    <= 1'b0;
            ack_q     <= rx_q[9:8];
            rdat_q    <= rx_q[7:0];
            state_q   <= H_IDLE;
          end
        end
        default: state_q <= H_IDLE;
      endcase
    end
  end
endmodule : vsr_host

// ---- verification/vsr_link_asserts.sv ----
`timescale 1ns/1ps
module vsr_link_asserts (
  input wire logic CORE_CLK,
  input wire logic RSTN,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic host_sdio_o,
  input wire logic host_sdio_oe,
  input wire logic dev_sdio_o,
  input wire logic dev_sdio_oe,
  input wire logic sdio
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  AST_ONE_DRIVER: assert property (!(host_sdio_oe && dev_sdio_oe))
    else $error("both ends drive the data wire");
  AST_IDLE_SCLK: assert property (cs_n |-> !sclk)
    else $error("link clock runs outside a frame");
  AST_SCLK_HALF: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk[*8] ##1 !sclk)
    else $error("link clock high time wrong");
  AST_HOST_STABLE: assert property (sclk && $past(sclk) && host_sdio_oe |->
    $stable(host_sdio_o)) else $error("host data moved while clock high");
  AST_DEV_STABLE: assert property (sclk && $past(sclk) && dev_sdio_oe |->
    $stable(dev_sdio_o)) else $error("device data moved while clock high");
  AST_DEV_QUIET: assert property (cs_n |-> !dev_sdio_oe)
    else $error("device drives while not selected");
  AST_HOST_START: assert property ($fell(cs_n) |-> host_sdio_oe && !sclk)
    else $error("frame start without host drive");
  AST_PULLUP: assert property (!host_sdio_oe && !dev_sdio_oe |-> sdio)
    else $error("released wire not high");
  AST_CS_END: assert property ($rose(cs_n) |-> !sclk && !$past(sclk, 8))
    else $error("frame closed too soon after clock");
  COV_FRAME: cover property ($rose(cs_n));
endmodule : vsr_link_asserts

// ---- verification/vid_serial_register_set_tb.sv ----
`timescale 1ns/1ps
module vid_serial_register_set_tb;
  import vsr_pkg::*;
  logic                  clk = 0, rstn = 0, en = 0, hsel = 0, hwrite = 0, take = 0;
  logic                  hready, hresp, alert;
  logic [1:0]            htrans = 0;
  logic [31:0]           haddr = 0, hwdata = 0, hrdata, rd;
  logic [7:0]            vout = 0, iout = 0, temp = 0, st2 = 0, strap = 0, t;
  logic [15:0]           p;
  logic [2:0]            bsel = 0;
  logic [NRAIL-1:0][7:0] vcode;
  logic [11:0]           ex;
  logic [11:0]           exq [$];
  logic [7:0]            ri [7] = '{IDX_FAST, IDX_SLOW, IDX_ALERT, IDX_CEIL, IDX_SETV,
                                    IDX_PSTATE, IDX_MARGIN};
  logic [7:0]            rv [7] = '{8'h0A, 8'h02, 8'h64, 8'hFB, 8'h00, 8'h00, 8'h00};
  int                    err_count = 0, num_checks = 0, n, k, c;
  always #12.5 clk = ~clk;
  vsr_link_if link ();
  vsr_host vsr_host_i (.CORE_CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .LINK(link.host));
  vsr_device vsr_device_i (.CORE_CLK(clk), .RSTN(rstn), .EN(en), .VOUT_MEAS(vout),
    .IOUT_MEAS(iout), .TEMP_MEAS(temp), .STATUS2_IN(st2), .CURRENT_LIMIT_STRAP_PIN(strap),
    .BOOT_STRAP_SEL(bsel), .LINK(link.dev), .THERMAL_ALERT_OUTPUT(alert),
    .VOLTAGE_CODE(vcode));
  vsr_link_asserts vsr_link_asserts_i (.CORE_CLK(clk), .RSTN(rstn), .sclk(link.sclk),
    .cs_n(link.cs_n), .host_sdio_o(link.host_sdio_o), .host_sdio_oe(link.host_sdio_oe),
    .dev_sdio_o(link.dev_sdio_o), .dev_sdio_oe(link.dev_sdio_oe), .sdio(link.sdio));
  task complete_run;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task fail(input string s);
    err_count++;
    $display("[ERR] %0t timeout %s", $time, s);
    complete_run();
  endtask : fail
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Status read results are compared against the oldest note
  always @(posedge clk) begin
    if (take) begin
      ex = exq.pop_front();
      num_checks++;
      if ((ex[11] && hrdata[2:1] !== ex[9:8]) || (ex[10] && hrdata[15:8] !== ex[7:0])) begin
        err_count++;
        $display("[ERR] %0t status %h expected %h", $time, hrdata[15:0], ex);
      end
    end
  end
  task ahb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic tk);
    @(posedge clk);
    hsel <= 1;
    haddr <= {28'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1) fail("bus");
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    take <= tk;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 100);
    rd = hrdata;
    take <= 0;
    if (hready !== 1'b1) fail("bus");
    chk({7'h0, hresp}, 8'h00);
  endtask : ahb
  // ak = {check ack, ack}, ed = {check data, data}
  task frame(input logic [3:0] rail, input logic [3:0] cmd, input logic [7:0] b1,
             input logic [7:0] b0, input logic [2:0] ak, input logic [8:0] ed);
    ahb(1, HOFF_CTRL, {8'h0, rail, cmd, b1, b0}, 0);
    rd = 1;
    for (k = 0; k < 600 && rd[0] !== 1'b0; k++) ahb(0, HOFF_STATUS, 0, 0);
    if (rd[0] !== 1'b0) fail("link");
    exq.push_back({ak[2], ed[8], ak[1:0], ed[7:0]});
    ahb(0, HOFF_STATUS, 0, 1);
  endtask : frame
  task get(input logic [7:0] idx, input logic [7:0] exp);
    frame(ADDR_CORE, CMD_GET, idx, 0, {1'b1, ACK_OK}, {1'b1, exp});
  endtask : get
  task setr(input logic [7:0] idx, input logic [7:0] val);
    frame(ADDR_CORE, CMD_SET, idx, val, {1'b1, ACK_OK}, 0);
  endtask : setr
  task vset(input logic [3:0] rail, input logic [3:0] cmd, input logic [7:0] v);
    frame(rail, cmd, v, 0, {1'b1, ACK_OK}, 0);
  endtask : vset
  task waitcode(input int r, input logic [7:0] v, input int bound);
    c = 0;
    while (vcode[r] !== v && c < bound) begin
      @(posedge clk);
      c++;
    end
    if (c >= bound) fail("ramp");
  endtask : waitcode
  task rng(input int lo, input int hi);
    chk({7'h0, c >= lo && c <= hi}, 8'h01);
  endtask : rng
  initial begin
    void'($urandom(29));
    repeat (20) @(posedge clk);
    rstn <= 1;
    vout <= 8'($urandom);
    iout <= 8'($urandom);
    st2 <= 8'($urandom);
    strap <= 8'($urandom);
    temp <= 8'h30;
    for (int s = 7; s >= 0; s--) begin
      en <= 0;
      bsel <= s[2:0];
      repeat (10) @(posedge clk);
      en <= 1;
      waitcode(0, BOOT_CODE_TBL[s], 20000);
      chk(vcode[1], BOOT_CODE_TBL[s]);
      get(IDX_BOOT, BOOT_CODE_TBL[s]);
    end
    foreach (ri[i]) get(ri[i], rv[i]);
    get(IDX_ICC, strap);
    frame(ADDR_CORE, CMD_SET, IDX_ICC, ~strap, {1'b1, ACK_REJECT}, 0);
    get(IDX_ICC, strap);
    p = vout * iout;
    get(IDX_POWER, p[15:8]);
    get(IDX_TEMP, temp);
    get(IDX_STAT2, st2);
    t = st2;
    st2 <= ~st2;
    get(IDX_SNAP, t);
    setr(IDX_ALERT, 8'h50);
    temp <= 8'h50;
    repeat (10) @(posedge clk);
    chk({7'h0, alert}, 8'h01);
    temp <= 8'h4F;
    repeat (10) @(posedge clk);
    chk({7'h0, alert}, 8'h00);
    temp <= 8'h00;
    setr(IDX_ALERT, 8'h00);
    chk({7'h0, alert}, 8'h00);
    setr(IDX_CEIL, 8'hC0);
    frame(ADDR_CORE, CMD_FAST, 8'hC1, 0, {1'b1, ACK_REJECT}, 0);
    repeat (200) @(posedge clk);
    chk(vcode[0], 8'hAB);
    get(IDX_SETV, 8'h00);
    setr(IDX_CEIL, 8'hFB);
    vset(ADDR_CORE, CMD_FAST, 8'hF0);
    waitcode(0, 8'hF0, 3000);
    rng(900, 1450);
    get(IDX_SETV, 8'hF0);
    vset(ADDR_CORE, CMD_SLOW, 8'hAB);
    waitcode(0, 8'hAB, 9000);
    rng(6200, 7000);
    vset(ADDR_CORE, CMD_DECAY, 8'h90);
    waitcode(0, 8'h90, 20);
    setr(IDX_MARGIN, 8'hFF);
    waitcode(0, 8'h8F, 3000);
    setr(IDX_MARGIN, 8'h01);
    waitcode(0, 8'h91, 3000);
    setr(IDX_MARGIN, 8'h00);
    vset(ADDR_AUX, CMD_FAST, 8'h80);
    waitcode(1, 8'h80, 3000);
    frame(4'h2, CMD_FAST, 8'h70, 0, 3'h7, {1'b1, 8'hFF});
    chk(vcode[1], 8'h80);
    setr(IDX_SETV, 8'hA0);
    waitcode(0, 8'hA0, 3000);
    t = 8'($urandom);
    setr(IDX_PSTATE, t);
    get(IDX_PSTATE, t);
    complete_run();
  end
endmodule : vid_serial_register_set_tb
